// File: src/sbus_pkg.sv
// Constants and types shared by the serial bus master files
`default_nettype none
package sbus_pkg;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DATA  = 8'hB0;
  localparam logic [7:0] OFF_INDEX = 8'hB1;
  localparam logic [7:0] OFF_TADDR = 8'hB2;
  localparam logic [7:0] OFF_CTRL  = 8'hB3;
  localparam int CS_QUICK = 0;
  localparam int CS_ERR   = 1;
  localparam int CS_RDV   = 2;
  localparam int CS_BUSY  = 5;
  localparam int CS_ROM   = 6;
  localparam int TA_RNW   = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic       RNW_WRITE = 1'b0;
  localparam logic       RNW_READ  = 1'b1;
  localparam logic [6:0] ROM_TADDR = 7'h50;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SCL_KHZ        = 100;
  localparam int LINK_PERIOD_PS = 32000;
  localparam int SCL_PERIOD_PS  = 1_000_000_000 / SCL_KHZ;
  // Quarter period rounded up, so SCL never runs fast
  localparam int QTR_RAW = (SCL_PERIOD_PS / 4 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int QTR_CYC = (QTR_RAW < 1) ? 1 : QTR_RAW;

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam logic [3:0] ACK_BIT    = 4'h8;
  localparam logic [1:0] PH_LOW     = 2'h0;
  localparam logic [1:0] PH_RISE    = 2'h1;
  localparam logic [1:0] PH_HIGH    = 2'h2;
  localparam logic [1:0] PH_LAST    = 2'h3;
  localparam int         LOAD_BYTES = 32;
  localparam logic [1:0] DW_LAST    = 2'h3;
  localparam logic [7:0] DW_STEP    = 8'h04;
  localparam logic [7:0] LOAD_START = 8'h00;

  typedef enum logic [2:0] {OP_START, OP_WR, OP_RD, OP_STOP} op_e;
  typedef enum logic [1:0] {K_QUICK, K_WRITE, K_READ, K_LOAD} kind_e;
  typedef enum logic [1:0] {LS_BOOT, LS_IDLE, LS_RUN} lstate_e;

  typedef struct packed {
    logic       quick;
    logic       rnw;
    logic [6:0] taddr;
    logic [7:0] idx;
    logic [7:0] wdata;
  } cmd_s;

  typedef struct packed {
    logic       err;
    logic       rdv;
    logic [7:0] rdata;
  } res_s;
endpackage
`default_nettype wire

// File: src/cdc_sync.sv
// Two flip-flop level synchroniser
`default_nettype none
module cdc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: src/scl_tick.sv
// Quarter bit period tick generator on the link clock
`default_nettype none
module scl_tick #(
  parameter int CYC = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic tick
);
  localparam int W = (CYC < 2) ? 1 : $clog2(CYC);
  localparam logic [W-1:0] LAST = W'(CYC - 1);
  localparam logic [W-1:0] ONE  = W'(1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + ONE;
    end
  end
endmodule
`default_nettype wire

// File: src/serial_bus_master.sv
// Two-wire serial bus master with byte registers and EEPROM autoload
// Function
// - EEPROM present when SCL reads high through its pullup after reset.
// - SCL toggles near but never above 100 kHz during transfers.
// - Writing the target address register while not busy starts a transaction.
// - Data register sends write byte and captures read byte.
// - Index byte sent as word address; skipped in quick command.
// - Control/status shows read valid, busy, error; holds protocol select.
// - Standard-mode master, 7-bit addressing, at most 100 kbit/s.
// - Start: SDA falls while SCL high.
// - Stop: SDA rises while SCL high.
// - SDA changes only while SCL is low, except for start and stop.
// - Eight-bit bytes, each followed by one acknowledge slot.
// - Receiver acknowledges by holding SDA low during ack clock high.
// - Sole master; SCL released and still when idle.
// - Doubleword reads come only from reset autoload, never software.
// - Byte write: start, address+0, index, data, ack checks, stop.
// - Missing acknowledge in a software transaction sets the error status bit.
// - Transmitted bytes go out most significant bit first.
// - Byte read uses direction 1; master acknowledges received bytes.
// - Target drives SDA in read data; master keeps driving SCL.
// - After reset, with EEPROM present, load defaults automatically.
// - Autoload addresses the EEPROM as 1010000b.
`default_nettype none
module serial_bus_master #(
  parameter int LOAD_BYTES = sbus_pkg::LOAD_BYTES,
  parameter int QTR_CYC    = sbus_pkg::QTR_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output var  logic [7:0]  cfg_rdata,
  input  wire logic        scl_i,
  output var  logic        scl_o,
  output var  logic        scl_oe,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  output var  logic        load_valid,
  output var  logic [7:0]  load_index,
  output var  logic [31:0] load_data,
  output var  logic        load_done
);
  import sbus_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0]  data_q;
  logic [7:0]  idx_q;
  logic [7:0]  taddr_q;
  logic        quick_q;
  logic        err_q;
  logic        rdv_q;
  logic        busy_q;
  cmd_s        cmd_q;
  logic        req_tgl_q;
  logic        done_seen_q;
  logic        load_seen_q;
  logic [4:0]  cs_s;
  logic        done_s;
  logic        load_s;
  logic        loading_s;
  logic        rom_s;
  logic        boot_s;
  logic        wr_data;
  logic        wr_idx;
  logic        wr_taddr;
  logic        wr_ctrl;
  logic        start_go;
  logic        done_ev;
  logic        load_ev;
  logic [7:0]  cs_rd;

  lstate_e     ls_q;
  kind_e       kind_q;
  logic [2:0]  ls_s;
  logic        scl_s;
  logic        sda_s;
  logic        req_s;
  logic        req_seen_q;
  logic        tick;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [2:0]  step_q;
  logic [7:0]  sh_q;
  logic [7:0]  cur;
  logic        scl_lo_q;
  logic        sda_lo_q;
  logic        abort_q;
  logic        nack_q;
  logic [1:0]  rb_q;
  logic        rom_q;
  logic        loading_q;
  logic        boot_done_q;
  logic [7:0]  loff_q;
  logic [8:0]  nxt_off;
  logic        more_load;
  op_e         op;
  logic [7:0]  obyte;
  logic [6:0]  tgt;
  logic [7:0]  ix;
  logic        is_byte;
  logic        op_fin;
  logic        txn_fin;
  logic        txn_go;
  res_s        res_q;
  logic        done_tgl_q;
  logic [31:0] dw_q;
  logic [31:0] ld_dw_q;
  logic [7:0]  ld_idx_q;
  logic        load_tgl_q;

  // ---------------------------------------------------------------
  // Register decode, host clock
  // ---------------------------------------------------------------
  assign wr_data  = cfg_wr && (cfg_addr == OFF_DATA);
  assign wr_idx   = cfg_wr && (cfg_addr == OFF_INDEX);
  assign wr_taddr = cfg_wr && (cfg_addr == OFF_TADDR);
  assign wr_ctrl  = cfg_wr && (cfg_addr == OFF_CTRL);
  // A start while busy would corrupt the held command, so it is dropped
  assign start_go = wr_taddr && !busy_q;

  cdc_sync #(
    .W(5)
  ) u_csync (
    .clk  (clk),
    .rst_n(rst_n),
    .d    ({done_tgl_q, load_tgl_q, loading_q, rom_q, boot_done_q}),
    .q    (cs_s)
  );

  assign done_s    = cs_s[4];
  assign load_s    = cs_s[3];
  assign loading_s = cs_s[2];
  assign rom_s     = cs_s[1];
  assign boot_s    = cs_s[0];
  assign done_ev   = (done_s != done_seen_q);
  assign load_ev   = (load_s != load_seen_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_q <= REG_RESET;
    else if (done_ev && res_q.rdv)
      data_q <= res_q.rdata;
    else if (wr_data)
      data_q <= cfg_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q   <= REG_RESET;
      taddr_q <= REG_RESET;
      quick_q <= 1'b0;
    end
    else
    begin
      if (wr_idx)
        idx_q <= cfg_wdata;
      if (start_go)
        taddr_q <= cfg_wdata;
      if (wr_ctrl)
        quick_q <= cfg_wdata[CS_QUICK];
    end
  end

  // Command is frozen here while the link side works on it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q     <= '0;
      req_tgl_q <= 1'b0;
    end
    else if (start_go)
    begin
      cmd_q.quick <= quick_q;
      cmd_q.rnw   <= cfg_wdata[TA_RNW];
      cmd_q.taddr <= cfg_wdata[7:1];
      cmd_q.idx   <= idx_q;
      cmd_q.wdata <= data_q;
      req_tgl_q   <= ~req_tgl_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q      <= 1'b0;
      done_seen_q <= 1'b0;
    end
    else
    begin
      done_seen_q <= done_s;
      if (start_go)
        busy_q <= 1'b1;
      else if (done_ev)
        busy_q <= 1'b0;
    end
  end

  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      err_q <= 1'b0;
    else if (done_ev && res_q.err)
      err_q <= 1'b1;
    else if (wr_ctrl && cfg_wdata[CS_ERR])
      err_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdv_q <= 1'b0;
    else if (done_ev && res_q.rdv)
      rdv_q <= 1'b1;
    else if (start_go || (cfg_rd && (cfg_addr == OFF_DATA)))
      rdv_q <= 1'b0;
  end

  always_comb
  begin
    cs_rd           = REG_RESET;
    cs_rd[CS_QUICK] = quick_q;
    cs_rd[CS_ERR]   = err_q;
    cs_rd[CS_RDV]   = rdv_q;
    cs_rd[CS_BUSY]  = busy_q || loading_s;
    cs_rd[CS_ROM]   = rom_s;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_rdata <= REG_RESET;
    else if (cfg_rd)
    begin
      case (cfg_addr)
        OFF_DATA:  cfg_rdata <= data_q;
        OFF_INDEX: cfg_rdata <= idx_q;
        OFF_TADDR: cfg_rdata <= taddr_q;
        OFF_CTRL:  cfg_rdata <= cs_rd;
        default:   cfg_rdata <= REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_seen_q <= 1'b0;
      load_valid  <= 1'b0;
      load_index  <= REG_RESET;
      load_data   <= '0;
      load_done   <= 1'b0;
    end
    else
    begin
      load_seen_q <= load_s;
      load_valid  <= load_ev;
      load_done   <= boot_s && !load_ev; // Done only after the last load strobe
      if (load_ev)
      begin
        load_index <= ld_idx_q;
        load_data  <= ld_dw_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Link side, link clock
  // ---------------------------------------------------------------
  cdc_sync #(
    .W(3)
  ) u_lsync (
    .clk  (link_clk),
    .rst_n(rst_n),
    .d    ({scl_i, sda_i, req_tgl_q}),
    .q    (ls_s)
  );

  assign scl_s = ls_s[2];
  assign sda_s = ls_s[1];
  assign req_s = ls_s[0];

  scl_tick #(
    .CYC(QTR_CYC)
  ) u_tick (
    .clk  (link_clk),
    .rst_n(rst_n),
    .tick (tick)
  );

  // Sequence table per transaction kind
  always_comb
  begin
    tgt   = (kind_q == K_LOAD) ? ROM_TADDR : cmd_q.taddr;
    ix    = (kind_q == K_LOAD) ? loff_q : cmd_q.idx;
    op    = OP_STOP;
    obyte = {tgt, RNW_WRITE};
    if (!abort_q)
    begin
      case (kind_q)
        K_QUICK:
        begin
          case (step_q)
            3'h0:    op = OP_START;
            3'h1:
            begin
              op    = OP_WR;
              obyte = {tgt, cmd_q.rnw};
            end
            default: op = OP_STOP;
          endcase
        end
        K_WRITE:
        begin
          case (step_q)
            3'h0:    op = OP_START;
            3'h1:    op = OP_WR;
            3'h2:
            begin
              op    = OP_WR;
              obyte = ix;
            end
            3'h3:
            begin
              op    = OP_WR;
              obyte = cmd_q.wdata;
            end
            default: op = OP_STOP;
          endcase
        end
        default:
        begin
          case (step_q)
            3'h0:    op = OP_START;
            3'h1:    op = OP_WR;
            3'h2:
            begin
              op    = OP_WR;
              obyte = ix;
            end
            3'h3:    op = OP_START;
            3'h4:
            begin
              op    = OP_WR;
              obyte = {tgt, RNW_READ};
            end
            3'h5:    op = OP_RD;
            default: op = OP_STOP;
          endcase
        end
      endcase
    end
  end

  assign is_byte   = (op == OP_WR) || (op == OP_RD);
  assign op_fin    = (ls_q == LS_RUN) && tick && (ph_q == PH_LAST) && (!is_byte || (bit_q == ACK_BIT));
  assign txn_fin   = op_fin && (op == OP_STOP);
  assign nxt_off   = {1'b0, loff_q} + {1'b0, DW_STEP};
  assign more_load = (kind_q == K_LOAD) && !abort_q && (nxt_off < 9'(LOAD_BYTES));
  assign txn_go    = ((ls_q == LS_BOOT) && tick && scl_s)
                  || ((ls_q == LS_IDLE) && tick && (req_s != req_seen_q))
                  || (txn_fin && more_load);
  assign cur       = (bit_q == '0) ? obyte : sh_q;

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ls_q        <= LS_BOOT;
      kind_q      <= K_QUICK;
      req_seen_q  <= 1'b0;
      rom_q       <= 1'b0;
      loading_q   <= 1'b0;
      boot_done_q <= 1'b0;
      loff_q      <= LOAD_START;
    end
    else
    begin
      case (ls_q)
        LS_BOOT:
        begin
          if (tick)
          begin
            rom_q <= scl_s;
            if (scl_s)
            begin
              kind_q    <= K_LOAD;
              loading_q <= 1'b1;
              loff_q    <= LOAD_START;
              ls_q      <= LS_RUN;
            end
            else
            begin
              boot_done_q <= 1'b1;
              ls_q        <= LS_IDLE;
            end
          end
        end
        LS_IDLE:
        begin
          if (tick && (req_s != req_seen_q))
          begin
            req_seen_q <= req_s;
            // Software can only pick quick, write or read
            kind_q <= cmd_q.quick ? K_QUICK : (cmd_q.rnw ? K_READ : K_WRITE);
            ls_q   <= LS_RUN;
          end
        end
        LS_RUN:
        begin
          if (txn_fin)
          begin
            if (more_load)
              loff_q <= nxt_off[7:0];
            else
            begin
              if (kind_q == K_LOAD)
              begin
                loading_q   <= 1'b0;
                boot_done_q <= 1'b1;
              end
              ls_q <= LS_IDLE;
            end
          end
        end
        default: ls_q <= LS_IDLE;
      endcase
    end
  end

  // Bit engine, four quarter phases per SCL period
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q     <= PH_LOW;
      bit_q    <= '0;
      step_q   <= '0;
      sh_q     <= REG_RESET;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
      abort_q  <= 1'b0;
      nack_q   <= 1'b0;
      rb_q     <= '0;
    end
    else if (txn_go)
    begin
      ph_q     <= PH_LOW;
      bit_q    <= '0;
      step_q   <= '0;
      abort_q  <= 1'b0;
      nack_q   <= 1'b0;
      rb_q     <= '0;
      scl_lo_q <= 1'b1;
      sda_lo_q <= 1'b0;
    end
    else if ((ls_q == LS_RUN) && tick)
    begin
      case (ph_q)
        PH_LOW:
        begin
          ph_q <= PH_RISE;
          // Data and ack bits move SDA only here, with SCL held low
          case (op)
            OP_START: sda_lo_q <= 1'b0;
            OP_STOP:  sda_lo_q <= 1'b1;
            OP_WR:
            begin
              sda_lo_q <= (bit_q == ACK_BIT) ? 1'b0 : ~cur[7];
              sh_q     <= cur;
            end
            default:  sda_lo_q <= (bit_q == ACK_BIT);
          endcase
        end
        PH_RISE:
        begin
          ph_q     <= PH_HIGH;
          scl_lo_q <= 1'b0;
        end
        PH_HIGH:
        begin
          ph_q <= PH_LAST;
          case (op)
            OP_START: sda_lo_q <= 1'b1;
            OP_STOP:  sda_lo_q <= 1'b0;
            OP_WR:
            begin
              if (bit_q == ACK_BIT)
                nack_q <= sda_s;
            end
            default:
            begin
              if (bit_q != ACK_BIT)
                sh_q <= {sh_q[6:0], sda_s};
            end
          endcase
        end
        default:
        begin
          ph_q <= PH_LOW;
          // SCL stays released after a stop
          if (op != OP_STOP)
            scl_lo_q <= 1'b1;
          if (op == OP_START)
            step_q <= step_q + 3'h1;
          else if (is_byte && (bit_q == ACK_BIT))
          begin
            bit_q <= '0;
            if ((op == OP_WR) && nack_q)
              abort_q <= 1'b1;
            else if (op == OP_RD)
            begin
              rb_q <= rb_q + 2'h1;
              if ((kind_q != K_LOAD) || (rb_q == DW_LAST))
                step_q <= step_q + 3'h1;
            end
            else
              step_q <= step_q + 3'h1;
          end
          else if (is_byte)
          begin
            bit_q <= bit_q + 4'h1;
            if (op == OP_WR)
              sh_q <= {sh_q[6:0], 1'b0};
          end
        end
      endcase
    end
    else if (ls_q != LS_RUN)
    begin
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end
  end

  // Results held stable until the next transaction ends
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_q      <= '0;
      done_tgl_q <= 1'b0;
      dw_q       <= '0;
      ld_dw_q    <= '0;
      ld_idx_q   <= LOAD_START;
      load_tgl_q <= 1'b0;
    end
    else
    begin
      if (op_fin && (op == OP_RD))
        dw_q <= {sh_q, dw_q[31:8]};
      if (txn_fin && (kind_q == K_LOAD))
      begin
        if (!abort_q)
        begin
          ld_dw_q    <= dw_q;
          ld_idx_q   <= loff_q;
          load_tgl_q <= ~load_tgl_q;
        end
      end
      else if (txn_fin)
      begin
        res_q.err   <= abort_q;
        res_q.rdv   <= (kind_q == K_READ) && !abort_q;
        res_q.rdata <= sh_q;
        done_tgl_q  <= ~done_tgl_q;
      end
    end
  end

  // Open drain: only ever pulls low
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_lo_q;
  assign sda_oe = sda_lo_q;
endmodule
`default_nettype wire

// File: testbench/serial_bus_master_props.sv
// Port assertions for the serial bus master
`default_nettype none
module serial_bus_master_props #(
  parameter int LOAD_BYTES = 32,
  parameter int QTR_CYC    = 79
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       link_clk,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_rdata,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic       load_valid,
  input wire logic [7:0] load_index,
  input wire logic       load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbus_pkg::*;
  localparam int QW   = 4 * QTR_CYC + 4;
  localparam int HALF = 2 * QTR_CYC;
  // ----------------------------------------
  // SCL phase length
  // ----------------------------------------
  // Saturates, idle stretches are long
  logic [9:0] run_q;
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= 10'h3FF;
    else if ($changed(scl_oe))
      run_q <= 10'h001;
    else if (run_q != 10'h3FF)
      run_q <= run_q + 10'h001;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_lo;
    @(posedge link_clk) disable iff (!rst_n) $fell(scl_oe) |-> run_q >= HALF - 1 && run_q <= HALF + 1;
  endproperty
  a_lo: assert property (p_lo) else $error("SCL low phase length");
  property p_hi;
    @(posedge link_clk) disable iff (!rst_n) $rose(scl_oe) |-> run_q >= HALF - 1;
  endproperty
  a_hi: assert property (p_hi) else $error("SCL high phase short");
  property p_sta;
    @(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) && !scl_oe |=> !scl_oe ##[1:QW] scl_oe;
  endproperty
  a_sta: assert property (p_sta) else $error("start not followed by clock");
  property p_sto;
    @(posedge link_clk) disable iff (!rst_n) $fell(sda_oe) && !scl_oe |-> (!scl_oe && !sda_oe) [*3];
  endproperty
  a_sto: assert property (p_sto) else $error("bus not released after stop");
  property p_udr;
    @(posedge clk) disable iff (!rst_n) cfg_rd && (cfg_addr < OFF_DATA || cfg_addr > OFF_CTRL) |=> cfg_rdata == 8'h00;
  endproperty
  a_udr: assert property (p_udr) else $error("unmapped read not zero");
  property p_hold;
    @(posedge clk) disable iff (!rst_n) !cfg_rd |=> $stable(cfg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_lv;
    @(posedge clk) disable iff (!rst_n) load_valid |-> !load_done && load_index[1:0] == 2'h0 && load_index < LOAD_BYTES ##1 !load_valid;
  endproperty
  a_lv: assert property (p_lv) else $error("bad load strobe");
  property p_ld;
    @(posedge clk) disable iff (!rst_n) load_done |=> load_done;
  endproperty
  a_ld: assert property (p_ld) else $error("load done dropped");
  c_load: cover property (@(posedge clk) disable iff (!rst_n) load_valid);
  c_start: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) && !scl_oe);
  c_udr: cover property (@(posedge clk) disable iff (!rst_n) cfg_rd && cfg_addr > OFF_CTRL);
endmodule
`default_nettype wire

// File: testbench/eeprom_model.sv
// Behavioural EEPROM slave on the two-wire bus
`default_nettype none
module eeprom_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic       act;
  logic       adr;
  logic       rd;
  logic       first;
  int         n;
  int         nb;
  // Bit 7 set in every byte below 80h: the master acks the last byte too, so a real part keeps driving
  initial
  begin
    pull = 1'b0;
    act = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'hA5;
  end
  always @(negedge sda)
  begin
    if (scl)
    begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      n = 0;
      nb = 0;
    end
  end
  always @(posedge sda)
  begin
    if (scl)
    begin
      act = 1'b0;
      pull = 1'b0;
    end
  end
  always @(posedge scl)
  begin
    if (act)
    begin
      if (n < 8)
        sh = {sh[6:0], sda};
      n++;
    end
  end
  // Changes only on falling SCL
  always @(negedge scl)
  begin
    if (act)
    begin
      pull = 1'b0;
      if (n == 8)
      begin
        nb++;
        if (adr)
        begin
          pull = (sh[7:1] == ADDR);
          rd = sh[0];
          act = pull;
          first = 1'b1;
        end
        else if (rd)
          ptr++;
        else
        begin
          if (first)
            ptr = sh;
          else
            mem[ptr++] = sh;
          first = 1'b0;
          pull = 1'b1;
        end
      end
      else if (n == 9)
      begin
        n = 0;
        adr = 1'b0;
      end
      if (rd && !adr && n < 8)
        pull = !mem[ptr][7 - n];
    end
  end
endmodule
`default_nettype wire

// File: testbench/serial_bus_master_bench.sv
// Self-checking bench for the serial bus master
`default_nettype none
module serial_bus_master_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sbus_pkg::*;
  localparam int Q  = 4;
  localparam int LB = 8;
  logic        clk;
  logic        rst_n;
  logic        link_clk;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic        scl_o;
  logic        scl_oe;
  logic        sda_o;
  logic        sda_oe;
  logic        load_valid;
  logic [7:0]  load_index;
  logic [31:0] load_data;
  logic        load_done;
  logic        pull;
  logic [7:0]  v;
  wire         scl;
  wire         sda;
  int          bad_count;
  int          check_count;
  int          nload;
  // Pull-ups on both wires
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_oe ? sda_o : 1'b1) & !pull;
  serial_bus_master #(.LOAD_BYTES(LB), .QTR_CYC(Q)) dut_u (
    .clk        (clk),
    .rst_n      (rst_n),
    .link_clk   (link_clk),
    .cfg_wr     (cfg_wr),
    .cfg_rd     (cfg_rd),
    .cfg_addr   (cfg_addr),
    .cfg_wdata  (cfg_wdata),
    .cfg_rdata  (cfg_rdata),
    .scl_i      (scl),
    .scl_o      (scl_o),
    .scl_oe     (scl_oe),
    .sda_i      (sda),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .load_valid (load_valid),
    .load_index (load_index),
    .load_data  (load_data),
    .load_done  (load_done)
  );
  eeprom_model rom_u (.scl(scl), .sda(sda), .pull(pull));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.1;
    forever #16 link_clk = ~link_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] ev(input int i);
    return 8'(i) ^ 8'hA5;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %0t seen %0h exp %0h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
    @(negedge clk);
    d = cfg_rdata;
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    int         i;
    for (i = 0; i < 2000; i++)
    begin
      rd(OFF_CTRL, s);
      if (s[CS_BUSY] === 1'b0)
        break;
    end
    if (i == 2000)
    begin
      bad_count++;
      wrap_up;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (load_valid === 1'b1)
    begin
      chk(32'(load_index), 32'(nload * 4));
      chk(load_data, {ev(nload * 4 + 3), ev(nload * 4 + 2), ev(nload * 4 + 1), ev(nload * 4)});
      nload++;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    bad_count = 0;
    check_count = 0;
    nload = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 40000 && load_done !== 1'b1; i++)
      @(negedge clk);
    if (load_done !== 1'b1)
    begin
      bad_count++;
      wrap_up;
    end
    rd(OFF_CTRL, v);
    chk(v, 8'h40);
    chk(nload, LB / 4);
    wr(OFF_INDEX, 8'h10);
    wr(OFF_DATA, 8'hC3);
    wr(OFF_TADDR, 8'hA0);
    wr(OFF_TADDR, 8'h47);
    rd(OFF_CTRL, v);
    chk(v[CS_BUSY], 1'b1);
    wait_idle;
    rd(OFF_TADDR, v);
    chk(v, 8'hA0);
    rd(OFF_CTRL, v);
    chk(v, 8'h40);
    chk(rom_u.mem[8'h10], 8'hC3);
    chk(rom_u.nb, 3);
    wr(OFF_INDEX, 8'h11);
    wr(OFF_TADDR, 8'hA1);
    wait_idle;
    rd(OFF_CTRL, v);
    chk(v, 8'h44);
    rd(OFF_DATA, v);
    chk(v, ev(8'h11));
    rd(OFF_CTRL, v);
    chk(v, 8'h40);
    wr(OFF_TADDR, 8'h46);
    wait_idle;
    rd(OFF_CTRL, v);
    chk(v, 8'h42);
    wr(OFF_CTRL, 8'h02);
    rd(OFF_CTRL, v);
    chk(v, 8'h40);
    wr(OFF_CTRL, 8'h01);
    wr(OFF_INDEX, 8'h20);
    wr(OFF_DATA, 8'h99);
    wr(OFF_TADDR, 8'hA0);
    wait_idle;
    rd(OFF_CTRL, v);
    chk(v, 8'h41);
    chk(rom_u.nb, 1);
    chk(rom_u.mem[8'h20], ev(8'h20));
    rd(8'hB4, v);
    chk(v, 8'h00);
    chk(nload, LB / 4);
    wrap_up;
  end
endmodule
bind serial_bus_master serial_bus_master_props #(.LOAD_BYTES(LOAD_BYTES), .QTR_CYC(QTR_CYC)) props_u (
  .clk        (clk),
  .rst_n      (rst_n),
  .link_clk   (link_clk),
  .cfg_rd     (cfg_rd),
  .cfg_addr   (cfg_addr),
  .cfg_rdata  (cfg_rdata),
  .scl_oe     (scl_oe),
  .sda_oe     (sda_oe),
  .load_valid (load_valid),
  .load_index (load_index),
  .load_done  (load_done)
);
`default_nettype wire
